// [logic/scm_strap_mux.sv]
// strap capture, mode outputs and pin alternate function mux with AXI4-Lite registers
// assumes strap pins are stable from reset release until capture
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module scm_strap_mux (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // strap pins
    input  wire logic        i_iface_rgmii_strap,
    input  wire logic [4:0]  i_mgmt_address_straps,
    input  wire logic        i_broadcast_address_strap,
    input  wire logic        i_ref_clock_out_strap,
    input  wire logic        i_indicator_style_strap,
    input  wire logic [4:0]  i_indicator_polarity_straps,
    input  wire logic        i_jack_compat_strap,
    // primary functions from device logic
    input  wire logic [4:0]  i_led_on,
    input  wire logic        i_irq_n,
    input  wire logic        i_clk125_local,
    input  wire logic        i_clk125_recov,
    input  wire logic        i_crs,
    input  wire logic        i_col,
    input  wire logic        i_half_duplex,
    input  wire logic        i_power_event_n,
    // multi-function pins, index equals gpio number
    input  wire logic [9:0]  i_mfp_in,
    output logic      [9:0]  o_mfp_out,
    output logic      [9:0]  o_mfp_oe_n,
    // mode outputs
    output logic             o_straps_valid,
    output logic             o_rgmii_sel,
    output logic      [4:0]  o_mgmt_address,
    output logic             o_broadcast_en,
    output logic             o_indicator_style,
    output logic             o_jack_compat_preset,
    output logic             o_tx_err_int,
    // AXI4-Lite write
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic      [1:0]  o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic      [31:0] o_rdata,
    output logic      [1:0]  o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    typedef enum logic {SCM_SETTLE, SCM_RUN} scm_phase_t;

    typedef struct packed {
        scm_phase_t  phase;
        logic [3:0]  settle_cnt;
        logic [14:0] straps;
        logic [6:0]  common;
        logic [9:0]  gpio_en;
        logic [9:0]  gpio_dir;
        logic [9:0]  gpio_out;
        logic [4:0]  sel_one;
        logic [4:0]  sel_two;
        logic [9:0]  pin_out;
        logic [9:0]  pin_oe_n;
        logic        tx_err_int;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } scm_state_t;

    scm_state_t st_reg;
    scm_state_t st_next;
    logic [24:0] sync_q;
    logic [14:0] strap_sync;
    logic [9:0]  pin_sync;
    logic [9:0]  eff_en;
    logic [9:0]  sel_all;
    logic [9:0]  prim_out;
    logic [9:0]  prim_oe_n;

    scm_pin_sync #(
        .WIDTH (25)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_d       ({i_mfp_in, i_jack_compat_strap, i_indicator_polarity_straps,
                     i_indicator_style_strap, i_ref_clock_out_strap,
                     i_broadcast_address_strap, i_mgmt_address_straps,
                     i_iface_rgmii_strap}),
        .o_q       (sync_q)
    );
    assign strap_sync = sync_q[14:0];
    assign pin_sync   = sync_q[24:15];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // gpio takeover: crs/col only when RGMII or half duplex, tx error in any mode
    always_comb begin
        eff_en = st_reg.gpio_en;
        if (!(st_reg.straps[scm_pkg::SP_IFACE_RGMII] || i_half_duplex)) begin
            eff_en[scm_pkg::PIN_CRS] = 1'b0;
            eff_en[scm_pkg::PIN_COL] = 1'b0;
        end
        sel_all = {st_reg.sel_two, st_reg.sel_one};
    end

    // primary pin functions
    genvar gl;
    generate
        for (gl = 0; gl < scm_pkg::LED_W; gl = gl + 1) begin : g_led
            assign prim_out[gl]  = i_led_on[gl] ^ ~st_reg.common[scm_pkg::CC_IND_POL + gl];
            assign prim_oe_n[gl] = 1'b0;
        end
    endgenerate
    assign prim_out[scm_pkg::PIN_INT_N]        = 1'b0;
    assign prim_oe_n[scm_pkg::PIN_INT_N]       = i_irq_n;
    assign prim_out[scm_pkg::PIN_REF_CLK_OUT]  = st_reg.common[scm_pkg::CC_CLK_RECOV] ?
                                                 i_clk125_recov : i_clk125_local;
    assign prim_oe_n[scm_pkg::PIN_REF_CLK_OUT] = ~st_reg.straps[scm_pkg::SP_REF_CLK];
    assign prim_out[scm_pkg::PIN_TX_ERR]       = 1'b0;
    assign prim_oe_n[scm_pkg::PIN_TX_ERR]      = 1'b1;
    assign prim_out[scm_pkg::PIN_CRS]          = i_crs;
    assign prim_oe_n[scm_pkg::PIN_CRS]         = 1'b0;
    assign prim_out[scm_pkg::PIN_COL]          = i_col;
    assign prim_oe_n[scm_pkg::PIN_COL]         = 1'b0;

    always_comb begin
        st_next = st_reg;
        // write channel
        if (st_reg.bvalid && i_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (i_awvalid && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = i_awaddr;
        end
        if (i_wvalid && st_reg.wready) begin
            st_next.w_full = 1'b1;
            st_next.w_data = i_wdata;
            st_next.w_strb = i_wstrb;
        end
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = scm_pkg::RESP_OKAY;
            if (st_reg.aw_addr == scm_pkg::OFS_COMMON_CTRL) begin
                st_next.common = 7'(merge(32'(st_reg.common), st_reg.w_data, st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_GPIO_EN) begin
                st_next.gpio_en = 10'(merge(32'(st_reg.gpio_en), st_reg.w_data, st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_GPIO_DIR) begin
                st_next.gpio_dir = 10'(merge(32'(st_reg.gpio_dir), st_reg.w_data,
                                             st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_GPIO_OUT) begin
                st_next.gpio_out = 10'(merge(32'(st_reg.gpio_out), st_reg.w_data,
                                             st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_SEL_ONE) begin
                st_next.sel_one = 5'(merge(32'(st_reg.sel_one), st_reg.w_data, st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_SEL_TWO) begin
                st_next.sel_two = 5'(merge(32'(st_reg.sel_two), st_reg.w_data, st_reg.w_strb));
            end else if (st_reg.aw_addr == scm_pkg::OFS_STRAP_STATUS ||
                         st_reg.aw_addr == scm_pkg::OFS_GPIO_IN) begin
                st_next.bresp = scm_pkg::RESP_OKAY;
            end else begin
                st_next.bresp = scm_pkg::RESP_SLVERR;
            end
        end
        st_next.awready = !st_next.aw_full && !st_next.bvalid;
        st_next.wready  = !st_next.w_full && !st_next.bvalid;
        // read channel
        if (st_reg.rvalid && i_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (i_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = scm_pkg::RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            if (i_araddr == scm_pkg::OFS_STRAP_STATUS) begin
                st_next.rdata = 32'(st_reg.straps);
            end else if (i_araddr == scm_pkg::OFS_COMMON_CTRL) begin
                st_next.rdata = 32'(st_reg.common);
            end else if (i_araddr == scm_pkg::OFS_GPIO_EN) begin
                st_next.rdata = 32'(st_reg.gpio_en);
            end else if (i_araddr == scm_pkg::OFS_GPIO_DIR) begin
                st_next.rdata = 32'(st_reg.gpio_dir);
            end else if (i_araddr == scm_pkg::OFS_GPIO_OUT) begin
                st_next.rdata = 32'(st_reg.gpio_out);
            end else if (i_araddr == scm_pkg::OFS_GPIO_IN) begin
                st_next.rdata = 32'(pin_sync);
            end else if (i_araddr == scm_pkg::OFS_SEL_ONE) begin
                st_next.rdata = 32'(st_reg.sel_one);
            end else if (i_araddr == scm_pkg::OFS_SEL_TWO) begin
                st_next.rdata = 32'(st_reg.sel_two);
            end else begin
                st_next.rresp = scm_pkg::RESP_SLVERR;
            end
        end
        st_next.arready = !st_next.rvalid;
        // strap capture, then pin mux
        case (st_reg.phase)
            SCM_SETTLE: begin
                st_next.pin_out    = 10'h000;
                st_next.pin_oe_n   = 10'h3FF;
                st_next.tx_err_int = 1'b0;
                st_next.settle_cnt = st_reg.settle_cnt + 4'h1;
                if (st_reg.settle_cnt == scm_pkg::STRAP_SETTLE_CYCLES - 4'h1) begin
                    st_next.phase  = SCM_RUN;
                    st_next.straps = strap_sync;
                    st_next.common[scm_pkg::CC_BCAST_EN] =
                        ~strap_sync[scm_pkg::SP_BCAST];
                    st_next.common[scm_pkg::CC_CLK_RECOV] = 1'b0;
                    st_next.common[scm_pkg::CC_IND_POL +: scm_pkg::LED_W] =
                        ~strap_sync[scm_pkg::SP_IND_POL +: scm_pkg::LED_W];
                end
            end
            SCM_RUN: begin
                for (int p = 0; p < scm_pkg::GPIO_W; p++) begin
                    if (eff_en[p]) begin
                        st_next.pin_out[p]  = sel_all[p] ? i_power_event_n :
                                              st_reg.gpio_out[p];
                        st_next.pin_oe_n[p] = ~st_reg.gpio_dir[p];
                    end else begin
                        st_next.pin_out[p]  = prim_out[p];
                        st_next.pin_oe_n[p] = prim_oe_n[p];
                    end
                end
                st_next.tx_err_int = eff_en[scm_pkg::PIN_TX_ERR] ? 1'b0 :
                                     pin_sync[scm_pkg::PIN_TX_ERR];
            end
            default: begin
                st_next.phase = SCM_SETTLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg          <= '0;
            st_reg.pin_oe_n <= 10'h3FF;
            st_reg.gpio_en  <= scm_pkg::GPIO_EN_RST;
            st_reg.gpio_dir <= scm_pkg::GPIO_DIR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mfp_out            = st_reg.pin_out;
    assign o_mfp_oe_n           = st_reg.pin_oe_n;
    assign o_straps_valid       = st_reg.phase == SCM_RUN;
    assign o_rgmii_sel          = st_reg.straps[scm_pkg::SP_IFACE_RGMII];
    assign o_mgmt_address       = st_reg.straps[scm_pkg::SP_MGMT_ADDR +: 5];
    assign o_broadcast_en       = st_reg.common[scm_pkg::CC_BCAST_EN];
    assign o_indicator_style    = st_reg.straps[scm_pkg::SP_IND_STYLE];
    assign o_jack_compat_preset = st_reg.straps[scm_pkg::SP_JACK];
    assign o_tx_err_int         = st_reg.tx_err_int;
    assign o_awready            = st_reg.awready;
    assign o_wready             = st_reg.wready;
    assign o_bvalid             = st_reg.bvalid;
    assign o_bresp              = st_reg.bresp;
    assign o_arready            = st_reg.arready;
    assign o_rvalid             = st_reg.rvalid;
    assign o_rresp              = st_reg.rresp;
    assign o_rdata              = st_reg.rdata;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    sequence cap_s;
        st_reg.phase == SCM_SETTLE && st_reg.settle_cnt == 4'h7;
    endsequence

    iface_select_a: assert property (cap_s |=> o_rgmii_sel == $past(strap_sync[0])
        && o_straps_valid) else $error("interface select not captured");
    mgmt_address_a: assert property (cap_s |=> o_mgmt_address == $past(strap_sync[5:1]))
        else $error("management address not captured");
    bcast_default_a: assert property (cap_s |=> o_broadcast_en != $past(strap_sync[6]))
        else $error("broadcast enable not inverted strap");
    led_polarity_a: assert property (cap_s |=> st_reg.common[6:2] == ~st_reg.straps[13:9])
        else $error("led polarity default wrong");
    pins_quiet_a: assert property (!o_straps_valid |-> o_mfp_oe_n == 10'h3FF)
        else $error("pin driven before straps latched");
    ref_clock_a: assert property (o_straps_valid && !eff_en[6] && st_reg.straps[7]
        |=> !o_mfp_oe_n[6]) else $error("reference clock pin not driven");
    led_gpio_a: assert property (o_straps_valid && eff_en[0] && !sel_all[0]
        && st_reg.gpio_dir[0] |=> o_mfp_out[0] == $past(st_reg.gpio_out[0]) && !o_mfp_oe_n[0])
        else $error("led pin not used as gpio");
    crs_primary_a: assert property (o_straps_valid && !o_rgmii_sel && !i_half_duplex
        |=> o_mfp_out[8] == $past(i_crs)) else $error("carrier pin taken in full duplex");
    tx_err_hold_a: assert property (o_straps_valid && eff_en[7] |=> !o_tx_err_int)
        else $error("internal transmit error not held");
    power_event_a: assert property (o_straps_valid && eff_en[1] && sel_all[1]
        |=> o_mfp_out[1] == $past(i_power_event_n)) else $error("power event not routed");
    read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid [*1] ##0 !o_arready)
        else $error("read not answered next cycle");
endmodule

// [logic/scm_pkg.sv]
// constants for the strap capture and pin function mux block
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus
package scm_pkg;

    // register bus
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // register byte offsets
    localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
    localparam logic [7:0] OFS_COMMON_CTRL  = 8'h04;
    localparam logic [7:0] OFS_GPIO_EN      = 8'h08;
    localparam logic [7:0] OFS_GPIO_DIR     = 8'h0C;
    localparam logic [7:0] OFS_GPIO_OUT     = 8'h10;
    localparam logic [7:0] OFS_GPIO_IN      = 8'h14;
    localparam logic [7:0] OFS_SEL_ONE      = 8'h18;
    localparam logic [7:0] OFS_SEL_TWO      = 8'h1C;

    // captured strap vector layout
    localparam int unsigned STRAP_W        = 15;
    localparam int unsigned SP_IFACE_RGMII = 0;
    localparam int unsigned SP_MGMT_ADDR   = 1;
    localparam int unsigned SP_BCAST       = 6;
    localparam int unsigned SP_REF_CLK     = 7;
    localparam int unsigned SP_IND_STYLE   = 8;
    localparam int unsigned SP_IND_POL     = 9;
    localparam int unsigned SP_JACK        = 14;

    // common control fields
    localparam int unsigned CC_BCAST_EN  = 0;
    localparam int unsigned CC_CLK_RECOV = 1;
    localparam int unsigned CC_IND_POL   = 2;

    // multi-function pin indices, equal to their gpio numbers
    localparam int unsigned GPIO_W          = 10;
    localparam int unsigned LED_W           = 5;
    localparam int unsigned PIN_INT_N       = 5;
    localparam int unsigned PIN_REF_CLK_OUT = 6;
    localparam int unsigned PIN_TX_ERR      = 7;
    localparam int unsigned PIN_CRS         = 8;
    localparam int unsigned PIN_COL         = 9;

    // reset values
    localparam logic [9:0] GPIO_EN_RST  = 10'h000;
    localparam logic [9:0] GPIO_DIR_RST = 10'h000;

    // cycles from reset release to strap capture
    localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h8;

endpackage

// [logic/scm_pin_sync.sv]
// three-flop synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to i_clk_sys
`timescale 1ns/1ps
module scm_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                    o_q[gi]    <= 1'b0;
                end else begin
                    s1_reg[gi] <= i_d[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    // a change counts once stages two and three agree
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        o_q[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate
endmodule

// [dv/scm_board_model.sv]
// board side of the strap mux: strap resistors and pin levels seen by the pads
// assumes the profile input uses the strap status bit layout
`timescale 1ns/1ps
module scm_board_model (
    // board setup from the bench
    input  wire logic [14:0] i_profile,
    input  wire logic [9:0]  i_host_level,
    // pad drive from the block
    input  wire logic [9:0]  i_mfp_out,
    input  wire logic [9:0]  i_mfp_oe_n,
    // strap levels and resolved pin levels
    output logic             o_rgmii,
    output logic      [4:0]  o_addr,
    output logic             o_bcast,
    output logic             o_refclk,
    output logic             o_style,
    output logic      [4:0]  o_pol,
    output logic             o_jack,
    output logic      [9:0]  o_level
);
    // strap resistors follow the bench profile, which changes only while reset is held
    assign o_rgmii  = i_profile[scm_pkg::SP_IFACE_RGMII];
    assign o_addr   = i_profile[scm_pkg::SP_MGMT_ADDR +: 5];
    assign o_bcast  = i_profile[scm_pkg::SP_BCAST];
    assign o_refclk = i_profile[scm_pkg::SP_REF_CLK];
    assign o_style  = i_profile[scm_pkg::SP_IND_STYLE];
    assign o_pol    = i_profile[scm_pkg::SP_IND_POL +: 5];
    assign o_jack   = i_profile[scm_pkg::SP_JACK];
    // released led pins fall to their strap pull, others to the host level
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            if (!i_mfp_oe_n[k]) begin
                o_level[k] = i_mfp_out[k];
            end else if (k < 5) begin
                o_level[k] = o_pol[k];
            end else begin
                o_level[k] = i_host_level[k];
            end
        end
    end
endmodule

// [dv/tb_scm_strap_mux.sv]
// testbench for the strap capture and pin function mux
// assumes the board model resolves pads and the bench is the bus master
`timescale 1ns/1ps
module tb_scm_strap_mux;
    logic        clk, rst_n, awv, wv, bry, arv, rry, hdx, pev_n, crs, col, lclk;
    logic        awr, wr_r, bv, arr, rv, sv, rg, be, ist, jc, txe;
    logic        s_rg, s_bc, s_rc, s_st, s_jk;
    logic [4:0]  s_ma, s_pol, ma;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdata;
    logic [1:0]  bresp, rresp;
    logic [14:0] prof;
    logic [9:0]  host, lvl, mo, moe;
    int          fail_count, samples_checked;

    scm_strap_mux u_scm_strap_mux (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_iface_rgmii_strap(s_rg), .i_mgmt_address_straps(s_ma),
        .i_broadcast_address_strap(s_bc), .i_ref_clock_out_strap(s_rc),
        .i_indicator_style_strap(s_st), .i_indicator_polarity_straps(s_pol),
        .i_jack_compat_strap(s_jk), .i_led_on(5'h00), .i_irq_n(1'b1),
        .i_clk125_local(lclk), .i_clk125_recov(1'b0), .i_crs(crs), .i_col(col),
        .i_half_duplex(hdx), .i_power_event_n(pev_n), .i_mfp_in(lvl), .o_mfp_out(mo),
        .o_mfp_oe_n(moe), .o_straps_valid(sv), .o_rgmii_sel(rg), .o_mgmt_address(ma),
        .o_broadcast_en(be), .o_indicator_style(ist), .o_jack_compat_preset(jc),
        .o_tx_err_int(txe), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
        .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp),
        .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rry));

    scm_board_model u_scm_board_model (.i_profile(prof), .i_host_level(host),
        .i_mfp_out(mo), .i_mfp_oe_n(moe), .o_rgmii(s_rg), .o_addr(s_ma), .o_bcast(s_bc),
        .o_refclk(s_rc), .o_style(s_st), .o_pol(s_pol), .o_jack(s_jk), .o_level(lvl));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic hang;
        chk(32'h0000DEAD, 32'h00000000);
        conclude;
    endtask

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // write with both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ta, tw;
        int n;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 40 && !(ta && tw); n++) begin
            @(posedge clk);
            if (!ta && awr) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (!tw && wr_r) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        for (n = 0; n < 40 && !bv; n++) @(posedge clk);
        if (!bv) hang();
        bry <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rdw(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ta;
        int n;
        ta = 1'b0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 40 && !ta; n++) begin
            @(posedge clk);
            if (arr) begin
                ta = 1'b1;
                arv <= 1'b0;
            end
        end
        for (n = 0; n < 40 && !rv; n++) @(posedge clk);
        if (!rv) hang();
        rry <= 1'b0;
        chk(32'(rresp), 32'(er));
        chk(rdata, ed);
    endtask

    task automatic boot(input logic [14:0] p);
        int n;
        @(posedge clk);
        rst_n <= 1'b0;
        prof <= p;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        ticks(2);
        chk(32'(moe), 32'h000003FF);
        for (n = 0; n < 20 && !sv; n++) ticks(1);
        if (!sv) hang();
    endtask

    initial begin
        {rst_n, awv, wv, bry, arv, rry, hdx, crs, col, lclk} = '0;
        {awa, ara, wd} = '0;
        pev_n = 1'b1;
        prof = 15'h55A7;
        host = 10'h080;
        fail_count = 0;
        samples_checked = 0;
        boot(15'h55A7);
        chk(32'({rg, ma, be}), 32'h00000067);
        chk(32'({ist, jc}), 32'h00000003);
        rdw(scm_pkg::OFS_STRAP_STATUS, 32'(prof), scm_pkg::RESP_OKAY);
        rdw(scm_pkg::OFS_COMMON_CTRL, 32'h00000055, scm_pkg::RESP_OKAY);
        @(posedge clk) lclk <= 1'b1;
        ticks(3);
        chk(32'({moe[6], mo[6]}), 32'h00000001);
        wr(scm_pkg::OFS_COMMON_CTRL, 32'h00000057, scm_pkg::RESP_OKAY);
        ticks(2);
        chk(32'({moe[6], mo[6]}), 32'h00000000);
        wr(scm_pkg::OFS_STRAP_STATUS, 32'h00000000, scm_pkg::RESP_OKAY);
        rdw(scm_pkg::OFS_STRAP_STATUS, 32'(prof), scm_pkg::RESP_OKAY);
        wr(8'h40, 32'h00000001, scm_pkg::RESP_SLVERR);
        rdw(8'h40, 32'h00000000, scm_pkg::RESP_SLVERR);
        wr(scm_pkg::OFS_GPIO_DIR, 32'h000003FF, scm_pkg::RESP_OKAY);
        wr(scm_pkg::OFS_GPIO_OUT, 32'h000003FF, scm_pkg::RESP_OKAY);
        wr(scm_pkg::OFS_GPIO_EN, 32'h000003FF, scm_pkg::RESP_OKAY);
        ticks(2);
        chk(32'({moe, mo, txe}), 32'h000007FE);
        ticks(8);
        rdw(scm_pkg::OFS_GPIO_IN, 32'h000003FF, scm_pkg::RESP_OKAY);
        @(posedge clk) pev_n <= 1'b0;
        wr(scm_pkg::OFS_SEL_ONE, 32'h00000001, scm_pkg::RESP_OKAY);
        wr(scm_pkg::OFS_SEL_TWO, 32'h00000001, scm_pkg::RESP_OKAY);
        ticks(2);
        chk(32'(mo), 32'h000003DE);
        wr(scm_pkg::OFS_GPIO_EN, 32'h00000000, scm_pkg::RESP_OKAY);
        ticks(10);
        chk(32'(txe), 32'h00000001);
        chk(32'({moe[4:0], mo[4:0]}), 32'h0000000A);
        @(posedge clk) crs <= 1'b1;
        boot(15'h2A58);
        chk(32'({rg, ma, be}), 32'h00000018);
        ticks(2);
        chk(32'({ist, jc, moe[6]}), 32'h00000001);
        wr(scm_pkg::OFS_GPIO_EN, 32'h00000300, scm_pkg::RESP_OKAY);
        ticks(2);
        chk(32'({moe[9:8], mo[9:8]}), 32'h00000001);
        @(posedge clk) hdx <= 1'b1;
        ticks(3);
        chk(32'(moe[9:8]), 32'h00000003);
        conclude();
    end
endmodule
